// File: testbench/rpf_remote.sv
// far-side transceiver model: chip rate strobe and over-air loopback
`timescale 1ns/1ns
module rpf_remote (
    input  wire logic core_clk,
    input  wire logic nrst,
    input  wire logic tx_line,
    input  wire logic tx_chip_valid,
    output logic      chip_tick,
    output logic      rx_chip,
    output logic      rx_chip_valid
);
    logic [1:0] div;
    // frame order echoed chip for chip
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            div <= 2'h0; chip_tick <= 1'b0; rx_chip <= 1'b0; rx_chip_valid <= 1'b0;
        end else begin
            div <= div + 2'h1;
            chip_tick <= (div == 2'h3);
            rx_chip_valid <= tx_chip_valid;
            // idle line toggles every clock, starting from the inverse of its last chip
            rx_chip <= tx_chip_valid ? tx_line : ~rx_chip;
        end
    end
endmodule

// File: testbench/tb_radio_packet_framer_config.sv
// self-checking bench: registers, transmit framing, loopback receive, interrupt
`timescale 1ns/1ns
module tb_radio_packet_framer_config;
    logic core_clk = 1'b0, nrst = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, tx_start = 1'b0;
    logic [7:0] adr = 8'h00, tx_data = 8'h00, rd, rx_data;
    logic [31:0] dat = 32'h0, wb_dat_o;
    logic wb_ack_o, irq, tx_data_ready, chip_tick, tx_line, tx_chip_valid, tx_busy;
    logic rx_chip, rx_chip_valid, rx_data_valid, rx_fifo_clear;
    logic [47:0] chips = 48'h0;
    logic [7:0] pat [4];
    logic [7:0] rst_adr [8] = '{8'h58, 8'h5c, 8'h60, 8'h64, 8'h70, 8'h74, 8'h78, 8'h00};
    int n_errors = 0, checks_done = 0, nchip = 0, nrx = 0, k;
    logic [7:0] q [$];
    always #4 core_clk = ~core_clk;
    rpf_framer uut (.core_clk(core_clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .irq(irq), .tx_start(tx_start), .tx_length(7'h02),
        .tx_addr(8'h00), .tx_data(tx_data), .tx_data_ready(tx_data_ready),
        .chip_tick(chip_tick), .tx_line(tx_line), .tx_chip_valid(tx_chip_valid),
        .tx_busy(tx_busy), .rx_chip(rx_chip), .rx_chip_valid(rx_chip_valid),
        .rx_data(rx_data), .rx_data_valid(rx_data_valid), .rx_fifo_clear(rx_fifo_clear));
    rpf_remote far (.core_clk(core_clk), .nrst(nrst), .tx_line(tx_line),
        .tx_chip_valid(tx_chip_valid), .chip_tick(chip_tick), .rx_chip(rx_chip),
        .rx_chip_valid(rx_chip_valid));
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        @(posedge core_clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= {24'h0, d};
        n = 0;
        do begin @(posedge core_clk); n++; end while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o[7:0];
        cyc <= 1'b0; stb <= 1'b0;
        if (n >= 20) begin n_errors++; summarize(); end
    endtask
    always @(posedge core_clk) begin
        if (tx_chip_valid && nchip < 48) begin chips <= {chips[46:0], tx_line}; nchip++; end
        if (tx_data_ready) begin q.push_back(tx_data); tx_data <= 8'($urandom); end
        // payload survives coding off and on, crc on
        if (rx_data_valid) begin check(rx_data, q.pop_front()); nrx++; end
    end
    initial begin
        void'($urandom(32'he1ac78f6));
        repeat (20) @(posedge core_clk);
        nrst <= 1'b1;
        // register reset values, unmapped reads zero
        for (k = 0; k < 8; k++) begin wb(0, rst_adr[k], 0); check(rd, k == 6 ? 8'h40 : 8'h00); end
        for (k = 0; k < 4; k++) begin pat[k] = 8'($urandom); wb(1, rst_adr[k], pat[k]); end
        for (k = 0; k < 4; k++) begin wb(0, rst_adr[k], 0); check(rd, pat[k]); end
        wb(1, 8'h74, 8'h5a); wb(0, 8'h74, 0); check(rd, 8'h5a);
        wb(1, 8'h70, 8'h02); wb(1, 8'h48, 8'h38); wb(1, 8'h84, 8'h02);
        wb(1, 8'h78, 8'h29); wb(0, 8'h78, 0); check(rd, 8'h28);
        tx_data <= 8'($urandom);
        @(posedge core_clk) tx_start <= 1'b1;
        @(posedge core_clk) tx_start <= 1'b0;
        k = 0;
        while ((nrx < 2 || tx_busy !== 1'b0) && k < 3000) begin @(posedge core_clk); k++; end
        if (k >= 3000) begin n_errors++; summarize(); end
        repeat (4) @(posedge core_clk);
        // two preamble bytes then four pattern bytes
        check(chips, {8'haa, 8'haa, pat[0], pat[1], pat[2], pat[3]});
        check(irq, 1'b1);
        wb(0, 8'h78, 0); check(rd, 8'h29);
        wb(1, 8'h78, 8'h28); wb(0, 8'h78, 0); check(rd, 8'h29);
        wb(1, 8'h78, 8'h29); wb(0, 8'h78, 0); check(rd, 8'h28);
        wb(1, 8'h88, 8'h02); repeat (2) @(posedge core_clk); check(irq, 1'b0);
        // second frame with line coding on; payload checked by the loopback monitor
        wb(1, 8'h70, 8'h82);
        @(posedge core_clk) tx_start <= 1'b1;
        @(posedge core_clk) tx_start <= 1'b0;
        k = 0;
        while ((nrx < 4 || tx_busy !== 1'b0) && k < 3000) begin @(posedge core_clk); k++; end
        if (k >= 3000) begin n_errors++; summarize(); end
        repeat (4) @(posedge core_clk);
        check(irq, 1'b1);
        wb(0, 8'h78, 0); check(rd, 8'h29);
        summarize();
    end
endmodule

// File: verilog/rpf_framer.sv
// packet framer and deframer with wishbone configuration registers
//
// Implementation choice: the Wishbone slave port.
`timescale 1ns/1ns
// Function
// RULE1 - first pattern register is the first, most significant pattern byte sent
// RULE2 - second pattern register follows directly when pattern is two bytes or more
// RULE3 - third pattern register is sent third when pattern is three bytes or more
// RULE4 - last pattern register is sent last when pattern is four bytes
// RULE5 - line-coding bit enables Manchester coding on transmit and decoding on receive
// RULE6 - length field is payload size fixed, maximum length byte in variable mode
// RULE7 - node identifier register is used by receive address filtering
// RULE8 - framing-mode bit selects fixed length or variable length with length byte
// RULE9 - preamble code 00..11 sends one to four preamble bytes
// RULE10 - crc generated and checked only when enabled; scrambling only when enabled
// RULE11 - address filter: none, node, node or 0x00, node or 0x00 or 0xff
// RULE12 - status bit reports check result: one passed, zero failed
// RULE13 - writing one clears the status bit, writing zero leaves it
// RULE14 - pattern size picks 1 to 4 bytes from the first pattern register on
// RULE15 - receiver hunts for the start pattern only while recognition is enabled
// RULE16 - tolerance field accepts 0 to 3 bit errors in the pattern match
// RULE17 - failed check empties the receive fifo unless auto-clear bit is one
// RULE18 - frame order: preamble, pattern, length, address, payload, crc
// RULE19 - variable mode drops a packet whose length byte exceeds the maximum
module rpf_framer (
    input  logic        core_clk,
    input  logic        nrst,
    input  logic        wb_cyc_i,
    input  logic        wb_stb_i,
    input  logic        wb_we_i,
    input  logic [7:0]  wb_adr_i,
    input  logic [3:0]  wb_sel_i,
    input  logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic        wb_ack_o,
    output logic        irq,
    input  logic        tx_start,
    input  logic [6:0]  tx_length,
    input  logic [7:0]  tx_addr,
    input  logic [7:0]  tx_data,
    output logic        tx_data_ready,
    input  logic        chip_tick,
    output logic        tx_line,
    output logic        tx_chip_valid,
    output logic        tx_busy,
    input  logic        rx_chip,
    input  logic        rx_chip_valid,
    output logic [7:0]  rx_data,
    output logic        rx_data_valid,
    output logic        rx_fifo_clear
);
    function automatic rpf_pkg::rpf_sec_t next_sec(input rpf_pkg::rpf_sec_t s,
                                                   input rpf_pkg::rpf_cfg_t c,
                                                   input logic pay_nz);
        rpf_pkg::rpf_sec_t t;
        t = rpf_pkg::S_END;
        if (c.crc_en && s < rpf_pkg::S_CRC) t = rpf_pkg::S_CRC;
        if (pay_nz && s < rpf_pkg::S_PAY) t = rpf_pkg::S_PAY;
        if (c.filt != 2'b00 && s < rpf_pkg::S_ADDR) t = rpf_pkg::S_ADDR;
        if (c.var_len && s < rpf_pkg::S_LEN) t = rpf_pkg::S_LEN;
        if (s < rpf_pkg::S_SYNC) t = rpf_pkg::S_SYNC;
        return t;
    endfunction

    function automatic logic [6:0] sec_last(input rpf_pkg::rpf_sec_t s,
                                            input rpf_pkg::rpf_cfg_t c,
                                            input logic [6:0] plen);
        case (s)
            rpf_pkg::S_PRE:  sec_last = {5'h00, c.pre_len};
            rpf_pkg::S_SYNC: sec_last = {5'h00, c.psize};
            rpf_pkg::S_PAY:  sec_last = plen - 7'h01;
            rpf_pkg::S_CRC:  sec_last = 7'h01;
            default:         sec_last = 7'h00;
        endcase
    endfunction

    function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic b);
        crc_step = {crc[14:0], 1'b0} ^ ((crc[15] ^ b) ? rpf_pkg::CRC_POLY : 16'h0000);
    endfunction

    function automatic logic [8:0] pn_step(input logic [8:0] s);
        pn_step = {s[0] ^ s[5], s[8:1]};
    endfunction

    function automatic logic [5:0] popcount(input logic [31:0] v);
        popcount = 6'h00;
        for (int i = 0; i < 32; i++) popcount = popcount + {5'h00, v[i]};
    endfunction

    // ---------------- registers ----------------
    logic [7:0]                   pat [4];
    logic [7:0]                   line_len;
    logic [7:0]                   node_id;
    logic [7:0]                   framing;
    logic                         crc_ok;
    logic [7:0]                   rx_pattern;
    logic [7:0]                   autoclear;
    logic [rpf_pkg::EV_COUNT-1:0] irq_stat;
    logic [rpf_pkg::EV_COUNT-1:0] irq_en;
    logic [rpf_pkg::EV_COUNT-1:0] ev;
    rpf_pkg::rpf_cfg_t            cfg;

    wire [5:0] bus_idx = wb_adr_i[7:2];
    wire       bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire       bus_wr  = bus_req && wb_we_i && wb_sel_i[0];
    wire [7:0] wdat    = wb_dat_i[7:0];

    assign cfg.man_en  = line_len[rpf_pkg::MAN_BIT];
    // RULE6 length field
    assign cfg.max_len = line_len[6:0];
    assign cfg.var_len = framing[rpf_pkg::VAR_BIT];
    assign cfg.pre_len = framing[rpf_pkg::PRE_LSB +: 2];
    assign cfg.scr_en  = framing[rpf_pkg::SCR_BIT];
    assign cfg.crc_en  = framing[rpf_pkg::CRC_BIT];
    assign cfg.filt    = framing[rpf_pkg::FILT_LSB +: 2];
    assign cfg.recog   = rx_pattern[rpf_pkg::RECOG_BIT];
    assign cfg.psize   = rx_pattern[rpf_pkg::PSIZE_LSB +: 2];
    assign cfg.tol     = rx_pattern[rpf_pkg::TOL_LSB +: 2];
    assign cfg.autoclr = autoclear[rpf_pkg::AUTOCLR_BIT];

    function automatic logic [7:0] rd_mux(input logic [5:0] i);
        case (i)
            rpf_pkg::IDX_PAT_FIRST:  rd_mux = pat[0];
            rpf_pkg::IDX_PAT_SECOND: rd_mux = pat[1];
            rpf_pkg::IDX_PAT_THIRD:  rd_mux = pat[2];
            rpf_pkg::IDX_PAT_LAST:   rd_mux = pat[3];
            rpf_pkg::IDX_LINE_LEN:   rd_mux = line_len;
            rpf_pkg::IDX_NODE:       rd_mux = node_id;
            rpf_pkg::IDX_FRAMING:    rd_mux = {framing[7:1], crc_ok};
            rpf_pkg::IDX_RX_PATTERN: rd_mux = rx_pattern;
            rpf_pkg::IDX_AUTOCLEAR:  rd_mux = autoclear;
            rpf_pkg::IDX_IRQ_STAT:   rd_mux = {4'h0, irq_stat};
            rpf_pkg::IDX_IRQ_EN:     rd_mux = {4'h0, irq_en};
            default:                 rd_mux = 8'h00;
        endcase
    endfunction
    wire [7:0] rd_val = rd_mux(bus_idx);

    // ---------------- transmit ----------------
    rpf_pkg::rpf_sec_t tx_sec;
    logic [7:0]        tx_sh;
    logic [2:0]        tx_bitn;
    logic              tx_half;
    logic [6:0]        tx_idx;
    logic [15:0]       tx_crc;
    logic [8:0]        tx_lfsr;
    logic [6:0]        tx_plen;
    logic [7:0]        tx_addr_r;
    logic [7:0]        tx_load;

    // RULE10 scrambling zone
    wire tx_scr      = cfg.scr_en && tx_sec >= rpf_pkg::S_LEN;
    wire tx_bit      = tx_sh[7] ^ (tx_scr & tx_lfsr[0]);
    // RULE5 manchester encode
    wire tx_chip     = (cfg.man_en && tx_half) ? ~tx_bit : tx_bit;
    wire tx_active   = tx_sec != rpf_pkg::S_IDLE;
    wire tx_bit_done = chip_tick && tx_active && (!cfg.man_en || tx_half);
    wire tx_byte_end = tx_bit_done && tx_bitn == 3'd7;
    wire tx_crc_zone = tx_sec >= rpf_pkg::S_LEN && tx_sec <= rpf_pkg::S_PAY;
    wire tx_last     = tx_idx == sec_last(tx_sec, cfg, tx_plen);
    wire [15:0] next_tx_crc = (tx_bit_done && tx_crc_zone) ? crc_step(tx_crc, tx_sh[7])
                                                          : tx_crc;
    // RULE18 section order
    wire rpf_pkg::rpf_sec_t next_tx_sec = tx_last ? next_sec(tx_sec, cfg, tx_plen != 7'h00)
                                                  : tx_sec;
    wire [6:0] next_tx_idx = tx_last ? 7'h00 : tx_idx + 7'h01;
    wire [6:0] tx_want     = cfg.var_len ? tx_length : cfg.max_len;
    wire       tx_go       = tx_start && !tx_active;

    always_comb begin
        case (next_tx_sec)
            rpf_pkg::S_PRE:  tx_load = rpf_pkg::PREAMBLE_BYTE;
            // RULE1 RULE2 RULE3 RULE4 RULE14 pattern bytes in order
            rpf_pkg::S_SYNC: tx_load = pat[next_tx_idx[1:0]];
            rpf_pkg::S_LEN:  tx_load = {1'b0, tx_plen};
            rpf_pkg::S_ADDR: tx_load = tx_addr_r;
            rpf_pkg::S_PAY:  tx_load = tx_data;
            rpf_pkg::S_CRC:  tx_load = (next_tx_idx == 7'h00) ? next_tx_crc[15:8] : tx_crc[7:0];
            default:         tx_load = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            tx_sec    <= rpf_pkg::S_IDLE;
            tx_sh     <= 8'h00;
            tx_bitn   <= 3'd0;
            tx_half   <= 1'b0;
            tx_idx    <= 7'h00;
            tx_crc    <= rpf_pkg::CRC_INIT;
            tx_lfsr   <= rpf_pkg::PN_SEED;
            tx_plen   <= 7'h00;
            tx_addr_r <= 8'h00;
        end else if (tx_go) begin
            // RULE9 preamble first, count from code
            tx_sec    <= rpf_pkg::S_PRE;
            tx_sh     <= rpf_pkg::PREAMBLE_BYTE;
            tx_bitn   <= 3'd0;
            tx_half   <= 1'b0;
            tx_idx    <= 7'h00;
            tx_crc    <= rpf_pkg::CRC_INIT;
            tx_lfsr   <= rpf_pkg::PN_SEED;
            tx_plen   <= (tx_want > cfg.max_len) ? cfg.max_len : tx_want;
            tx_addr_r <= tx_addr;
        end else if (chip_tick && tx_active) begin
            tx_half <= cfg.man_en & ~tx_half;
            if (tx_bit_done) begin
                tx_bitn <= tx_bitn + 3'd1;
                tx_sh   <= {tx_sh[6:0], 1'b0};
                // RULE10 crc generated over length to payload
                tx_crc  <= cfg.crc_en ? next_tx_crc : tx_crc;
                if (tx_scr) tx_lfsr <= pn_step(tx_lfsr);
            end
            if (tx_byte_end) begin
                tx_sec <= (next_tx_sec == rpf_pkg::S_END) ? rpf_pkg::S_IDLE : next_tx_sec;
                tx_idx <= next_tx_idx;
                tx_sh  <= tx_load;
            end
        end
    end

    // ---------------- receive ----------------
    rpf_pkg::rpf_sec_t rx_sec;
    logic              rx_half;
    logic [31:0]       rx_win;
    logic [7:0]        rx_sh;
    logic [2:0]        rx_bitn;
    logic [6:0]        rx_idx;
    logic [6:0]        rx_plen;
    logic [15:0]       rx_crc;
    logic [8:0]        rx_lfsr;
    logic [31:0]       pat_word;
    logic [31:0]       pat_mask;

    always_comb begin
        case (cfg.psize)
            2'd0:    pat_word = {24'h000000, pat[0]};
            2'd1:    pat_word = {16'h0000, pat[0], pat[1]};
            2'd2:    pat_word = {8'h00, pat[0], pat[1], pat[2]};
            default: pat_word = {pat[0], pat[1], pat[2], pat[3]};
        endcase
        pat_mask = 32'hffffffff >> (5'd24 - {cfg.psize, 3'd0});
    end

    // RULE5 manchester decode keeps the first chip of each pair
    wire        rx_bit_v  = rx_chip_valid && (!cfg.man_en || !rx_half);
    wire [31:0] rx_nwin   = {rx_win[30:0], rx_chip};
    wire [5:0]  rx_errs   = popcount((rx_nwin ^ pat_word) & pat_mask);
    wire rpf_pkg::rpf_sec_t rx_first = next_sec(rpf_pkg::S_SYNC, cfg, cfg.max_len != 7'h00);
    // RULE15 RULE16 hunt with error tolerance
    wire rx_hit = cfg.recog && rx_sec == rpf_pkg::S_IDLE && rx_bit_v &&
                  rx_errs <= {4'h0, cfg.tol} && rx_first != rpf_pkg::S_END;
    wire rx_in    = rx_sec != rpf_pkg::S_IDLE && rx_bit_v;
    wire rx_dbit  = rx_chip ^ (cfg.scr_en & rx_lfsr[0]);
    wire [7:0] rx_byte = {rx_sh[6:0], rx_dbit};
    wire rx_byte_end   = rx_in && rx_bitn == 3'd7;
    wire [15:0] next_rx_crc = crc_step(rx_crc, rx_dbit);
    wire rx_last  = rx_idx == sec_last(rx_sec, cfg, rx_plen);
    wire rx_pay_nz = (rx_sec == rpf_pkg::S_LEN) ? rx_byte != 8'h00 : rx_plen != 7'h00;
    wire rpf_pkg::rpf_sec_t next_rx_sec = rx_last ? next_sec(rx_sec, cfg, rx_pay_nz) : rx_sec;
    // RULE7 RULE11 address filter
    wire rx_addr_ok = cfg.filt == 2'b00 || rx_byte == node_id ||
                      (cfg.filt[1] && rx_byte == rpf_pkg::BCAST_LOW) ||
                      (cfg.filt == 2'b11 && rx_byte == rpf_pkg::BCAST_HIGH);
    // RULE19 oversize length byte
    wire rx_len_bad = rx_sec == rpf_pkg::S_LEN && rx_byte > {1'b0, cfg.max_len};
    wire rx_drop    = rx_byte_end && (rx_len_bad ||
                      (rx_sec == rpf_pkg::S_ADDR && !rx_addr_ok));
    wire rx_end     = rx_byte_end && !rx_drop && next_rx_sec == rpf_pkg::S_END;
    wire rx_pass    = rx_end && (!cfg.crc_en || next_rx_crc == 16'h0000);
    wire rx_fail    = rx_end && cfg.crc_en && next_rx_crc != 16'h0000;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rx_sec  <= rpf_pkg::S_IDLE;
            rx_half <= 1'b0;
            rx_win  <= 32'h00000000;
            rx_sh   <= 8'h00;
            rx_bitn <= 3'd0;
            rx_idx  <= 7'h00;
            rx_plen <= 7'h00;
            rx_crc  <= rpf_pkg::CRC_INIT;
            rx_lfsr <= rpf_pkg::PN_SEED;
        end else begin
            if (rx_chip_valid) rx_half <= cfg.man_en & ~rx_half;
            if (rx_bit_v) rx_win <= rx_nwin;
            if (rx_hit) begin
                rx_sec  <= rx_first;
                rx_bitn <= 3'd0;
                rx_idx  <= 7'h00;
                rx_plen <= cfg.max_len;
                rx_crc  <= rpf_pkg::CRC_INIT;
                rx_lfsr <= rpf_pkg::PN_SEED;
            end else if (rx_in) begin
                rx_bitn <= rx_bitn + 3'd1;
                rx_sh   <= rx_byte;
                rx_crc  <= next_rx_crc;
                // RULE10 descramble only when enabled
                if (cfg.scr_en) rx_lfsr <= pn_step(rx_lfsr);
                if (rx_byte_end) begin
                    rx_sec <= (rx_drop || rx_end) ? rpf_pkg::S_IDLE : next_rx_sec;
                    rx_idx <= rx_last ? 7'h00 : rx_idx + 7'h01;
                    // RULE8 length byte in variable mode
                    if (rx_sec == rpf_pkg::S_LEN) rx_plen <= rx_byte[6:0];
                end
            end
        end
    end

    assign ev[rpf_pkg::EV_TX_DONE] = tx_byte_end && next_tx_sec == rpf_pkg::S_END;
    assign ev[rpf_pkg::EV_RX_OK]   = rx_pass;
    assign ev[rpf_pkg::EV_RX_FAIL] = rx_fail;
    assign ev[rpf_pkg::EV_RX_DROP] = rx_drop;

    // ---------------- register file and outputs ----------------
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pat        <= '{default: rpf_pkg::RST_ZERO};
            line_len   <= rpf_pkg::RST_ZERO;
            node_id    <= rpf_pkg::RST_ZERO;
            framing    <= rpf_pkg::RST_FRAMING;
            crc_ok     <= rpf_pkg::RST_FRAMING[rpf_pkg::STAT_BIT];
            rx_pattern <= rpf_pkg::RST_ZERO;
            autoclear  <= rpf_pkg::RST_ZERO;
            irq_en     <= 4'h0;
            irq_stat   <= 4'h0;
            wb_ack_o   <= 1'b0;
            wb_dat_o   <= 32'h00000000;
            irq        <= 1'b0;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_req ? {24'h000000, rd_val} : 32'h00000000;
            irq      <= |(irq_stat & irq_en);
            if (bus_wr) begin
                case (bus_idx)
                    rpf_pkg::IDX_PAT_FIRST:  pat[0] <= wdat;
                    rpf_pkg::IDX_PAT_SECOND: pat[1] <= wdat;
                    rpf_pkg::IDX_PAT_THIRD:  pat[2] <= wdat;
                    rpf_pkg::IDX_PAT_LAST:   pat[3] <= wdat;
                    rpf_pkg::IDX_LINE_LEN:   line_len <= wdat;
                    rpf_pkg::IDX_NODE:       node_id <= wdat;
                    rpf_pkg::IDX_FRAMING:    framing <= {wdat[7:1], 1'b0};
                    rpf_pkg::IDX_RX_PATTERN: rx_pattern <= {2'b00, wdat[5:1], 1'b0};
                    rpf_pkg::IDX_AUTOCLEAR:  autoclear <= {wdat[7], 7'h00};
                    rpf_pkg::IDX_IRQ_EN:     irq_en <= wdat[3:0];
                    default: ;
                endcase
            end
            // events win over a clear in the same cycle
            irq_stat <= (irq_stat & ~((bus_wr && bus_idx == rpf_pkg::IDX_IRQ_CLR) ?
                         wdat[3:0] : 4'h0)) | ev;
            // RULE12 RULE13 result bit, write one clears, pass wins
            if (rx_pass && cfg.crc_en) crc_ok <= 1'b1;
            else if (rx_fail) crc_ok <= 1'b0;
            else if (bus_wr && bus_idx == rpf_pkg::IDX_FRAMING && wdat[rpf_pkg::STAT_BIT])
                crc_ok <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            tx_line       <= 1'b0;
            tx_chip_valid <= 1'b0;
            tx_busy       <= 1'b0;
            tx_data_ready <= 1'b0;
            rx_data       <= 8'h00;
            rx_data_valid <= 1'b0;
            rx_fifo_clear <= 1'b0;
        end else begin
            tx_line       <= (chip_tick && tx_active) ? tx_chip : 1'b0;
            tx_chip_valid <= chip_tick && tx_active;
            tx_busy       <= tx_active;
            tx_data_ready <= tx_byte_end && next_tx_sec == rpf_pkg::S_PAY;
            rx_data       <= rx_byte;
            rx_data_valid <= rx_byte_end && rx_sec == rpf_pkg::S_PAY;
            // RULE17 clear fifo on failure unless kept
            rx_fifo_clear <= rx_fail && !cfg.autoclr;
        end
    end

    // RULE5 first chip of a pair
    logic man_first;
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            man_first <= 1'b0;
        end else if (chip_tick && tx_active && !tx_half) begin
            man_first <= tx_chip;
        end
    end

    // ---------------- assertions ----------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    sequence s_bus_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_enter_crc;
        (tx_sec != rpf_pkg::S_CRC) ##1 (tx_sec == rpf_pkg::S_CRC);
    endsequence

    chk_ack_one_cycle: assert property (s_bus_req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single-cycle answer");
    chk_status_clear: assert property ( // RULE13
        bus_wr && bus_idx == rpf_pkg::IDX_FRAMING && wdat[0] && !rx_pass |=> !crc_ok)
        else $error("status bit not cleared by write of one");
    chk_status_pass: assert property (rx_pass && cfg.crc_en |=> crc_ok) // RULE12
        else $error("passed check not reported");
    chk_fifo_clear: assert property (rx_fifo_clear |-> $past(rx_fail && !cfg.autoclr)) // RULE17
        else $error("fifo clear without failed check");
    chk_crc_gated: assert property (s_enter_crc |-> $past(cfg.crc_en)) // RULE10
        else $error("crc sent while disabled");
    chk_sync_first: assert property ( // RULE1
        tx_sec == rpf_pkg::S_PRE ##1 tx_sec == rpf_pkg::S_SYNC |-> tx_sh == $past(pat[0]))
        else $error("first pattern byte wrong");
    chk_start_pre: assert property (tx_go |=> tx_sec == rpf_pkg::S_PRE && tx_busy == 1'b0
                                   ##1 tx_busy)
        else $error("frame not started with preamble");
    chk_manch_pair: assert property ( // RULE5
        chip_tick && tx_active && cfg.man_en && tx_half |=> tx_line == !man_first)
        else $error("manchester pair not complementary");
    chk_len_drop: assert property ( // RULE19
        rx_byte_end && rx_len_bad |=> rx_sec == rpf_pkg::S_IDLE && !rx_data_valid)
        else $error("oversize packet not dropped");
endmodule

// File: verilog/rpf_pkg.sv
// shared constants and types of the radio packet framer
package rpf_pkg;
    // register indices; the bus byte address is four times the index
    localparam logic [5:0] IDX_PAT_FIRST  = 6'h16;
    localparam logic [5:0] IDX_PAT_SECOND = 6'h17;
    localparam logic [5:0] IDX_PAT_THIRD  = 6'h18;
    localparam logic [5:0] IDX_PAT_LAST   = 6'h19;
    localparam logic [5:0] IDX_LINE_LEN   = 6'h1c;
    localparam logic [5:0] IDX_NODE       = 6'h1d;
    localparam logic [5:0] IDX_FRAMING    = 6'h1e;
    localparam logic [5:0] IDX_RX_PATTERN = 6'h12;
    localparam logic [5:0] IDX_AUTOCLEAR  = 6'h1f;
    localparam logic [5:0] IDX_IRQ_STAT   = 6'h20;
    localparam logic [5:0] IDX_IRQ_EN     = 6'h21;
    localparam logic [5:0] IDX_IRQ_CLR    = 6'h22;
    // field positions
    localparam int MAN_BIT     = 7;
    localparam int VAR_BIT     = 7;
    localparam int PRE_LSB     = 5;
    localparam int SCR_BIT     = 4;
    localparam int CRC_BIT     = 3;
    localparam int FILT_LSB    = 1;
    localparam int STAT_BIT    = 0;
    localparam int RECOG_BIT   = 5;
    localparam int PSIZE_LSB   = 3;
    localparam int TOL_LSB     = 1;
    localparam int AUTOCLR_BIT = 7;
    // reset values
    localparam logic [7:0] RST_ZERO    = 8'h00;
    localparam logic [7:0] RST_FRAMING = 8'h40;
    // line constants
    localparam logic [7:0]  PREAMBLE_BYTE = 8'haa;
    localparam logic [7:0]  BCAST_LOW     = 8'h00;
    localparam logic [7:0]  BCAST_HIGH    = 8'hff;
    localparam logic [15:0] CRC_POLY      = 16'h1021;
    localparam logic [15:0] CRC_INIT      = 16'hffff;
    localparam logic [8:0]  PN_SEED       = 9'h1ff;
    // interrupt event bits
    localparam int EV_TX_DONE = 0;
    localparam int EV_RX_OK   = 1;
    localparam int EV_RX_FAIL = 2;
    localparam int EV_RX_DROP = 3;
    localparam int EV_COUNT   = 4;

    typedef enum logic [2:0] {
        S_IDLE, S_PRE, S_SYNC, S_LEN, S_ADDR, S_PAY, S_CRC, S_END
    } rpf_sec_t;

    typedef struct packed {
        logic       man_en;
        logic [6:0] max_len;
        logic       var_len;
        logic [1:0] pre_len;
        logic       scr_en;
        logic       crc_en;
        logic [1:0] filt;
        logic       recog;
        logic [1:0] psize;
        logic [1:0] tol;
        logic       autoclr;
    } rpf_cfg_t;
endpackage
